// file: bmd_decoder.v
// Branch, call and index-modify decode and execute stage of the sequencer
//
// Function
// - Modify adds M to I, condition gates all
// - Modify opcode 000 00100, generator, predicate_select, I, M
// - Absent condition means always-true predicate code
// - Empty compute field executes as no-operation
// - Direct branch target is 24-bit absolute address
// - Relative direct branch adds sign-extended 24-bit offset
// - Type bit picks jump or call; call pushes
// - Delay bit keeps or discards following instructions
// - Loop abort pops loop and PC stacks
// - Same interrupt ignored while its routine runs
// - Clear-interrupt jump clears latch and pointer bit
// - Calls ignore loop abort and clear-interrupt bits
// - Indirect target is I plus M, I kept
// - Short relative branch adds sign-extended 6-bit offset
// - Without ELSE, branch if true, compute alongside
// - With ELSE, compute if false, branch if true
// - ELSE bit selects parallel or alternative compute
// - Opcodes 000 01000 indirect, 000 01001 relative
`timescale 1ns/1ps
`default_nettype none

`include "bmd_regs.vh"

module bmd_decoder #(
  parameter DAG_W = 32,
  parameter NUM_IRQ = 32,
  parameter IRQ_IDX_W = 5,
  parameter NUM_PREDICATE_SELECT = 32
) (
  input wire clock_i, // Core clock, 40 MHz
  input wire rst_n_i, // Synchronous reset, active low
  input wire instr_valid_i, // Instruction word valid this cycle
  input wire [47:0] instr_i, // Instruction word
  input wire [23:0] pc_i, // Address of the instruction
  input wire [NUM_PREDICATE_SELECT-1:0] predicate_select_flags_i, // Predicate results by code
  input wire dag_wr_en_i, // Software write to a DAG register
  input wire [4:0] dag_wr_sel_i, // Bit 4 modify/index, 3 generator
  input wire [DAG_W-1:0] dag_wr_data_i, // DAG write data
  input wire dag_rd_en_i, // DAG register read strobe
  input wire [4:0] dag_rd_sel_i, // DAG read select
  output reg [DAG_W-1:0] dag_rd_data_o, // DAG read data, next cycle
  input wire [NUM_IRQ-1:0] irq_req_i, // Interrupt request pulses
  input wire isr_enter_i, // Service routine starts
  input wire [IRQ_IDX_W-1:0] isr_num_i, // Interrupt being serviced
  output reg [NUM_IRQ-1:0] interrupt_latch_reg_o, // Latched requests
  output reg [NUM_IRQ-1:0] interrupt_mask_pointer_o, // Routines in service
  output reg branch_o, // Branch taken pulse
  output reg call_o, // Call pulse, push return_addr_o
  output reg delayed_branch_o, // Taken branch is delayed
  output reg flush_o, // Discard fetched instructions
  output reg [23:0] target_o, // Branch target
  output reg [23:0] return_addr_o, // Address pushed by a call
  output reg [23:0] next_pc_o, // Next fetch address
  output reg loop_pop_o, // Pop loop stacks pulse
  output reg pc_pop_o, // Pop PC stack pulse
  output reg compute_en_o, // Compute field executes pulse
  output reg [22:0] compute_o, // Compute field to execute
  output reg modify_done_o // Index register written pulse
);

  // Eight index and eight modify registers for each address generator
  localparam NUM_DAG = 16;

  reg [DAG_W-1:0] index_ff [0:NUM_DAG-1];
  reg [DAG_W-1:0] modify_ff [0:NUM_DAG-1];
  reg [NUM_IRQ-1:0] latch_ff;
  reg [NUM_IRQ-1:0] mask_ptr_ff;

  // Decoded instruction fields and per-form strobes
  wire [7:0] opcode;
  wire [4:0] predicate_select_code;
  wire predicate_select_ok;
  wire is_modify;
  wire is_jabs;
  wire is_jrel;
  wire is_ind;
  wire is_irel;
  wire is_branch;
  wire is_indgrp;
  wire is_call;
  wire has_else;
  wire is_delayed;
  wire [3:0] mod_isel;
  wire [3:0] mod_msel;
  wire [3:0] br_isel;
  wire [3:0] br_msel;
  wire [DAG_W-1:0] mod_sum;
  wire [DAG_W-1:0] br_sum;
  wire [5:0] rel6;
  wire [23:0] addr24;
  wire [22:0] comp_field;
  reg [23:0] target;

  // Branch outcome and its side effects
  wire take;
  wire jump_take;
  wire do_abort;
  wire do_clrint;
  wire mod_wr;
  wire comp_run;
  wire [23:0] pc_next;
  wire [23:0] pc_after_delay;

  // Interrupt latch and service pointer next state
  wire [NUM_IRQ-1:0] cur_irq;
  wire [NUM_IRQ-1:0] clr_vec;
  wire [NUM_IRQ-1:0] enter_vec;
  wire [NUM_IRQ-1:0] irq_one;
  wire [NUM_IRQ-1:0] nxt_latch;
  wire [NUM_IRQ-1:0] nxt_mask_ptr;

  assign opcode = instr_i[`BMD_OP_HI:`BMD_OP_LO];
  assign predicate_select_code = instr_i[`BMD_PREDICATE_SELECT_HI:`BMD_PREDICATE_SELECT_LO];
  // Code all-ones executes regardless of the flag vector
  assign predicate_select_ok = (predicate_select_code == `BMD_PREDICATE_SELECT_TRUE) | predicate_select_flags_i[predicate_select_code];

  // Only a valid word is decoded; other opcodes fall through as plain steps
  assign is_modify = instr_valid_i & (opcode == `BMD_OP_MODIFY);
  assign is_jabs = instr_valid_i & (opcode == `BMD_OP_JUMP_ABS);
  assign is_jrel = instr_valid_i & (opcode == `BMD_OP_JUMP_REL);
  assign is_ind = instr_valid_i & (opcode == `BMD_OP_IND);
  assign is_irel = instr_valid_i & (opcode == `BMD_OP_IND_REL);
  assign is_indgrp = is_ind | is_irel;
  assign is_branch = is_jabs | is_jrel | is_indgrp;

  // Bit 39 doubles as generator select for modify and call select for branches
  assign is_call = instr_i[`BMD_CALL_BIT];
  assign is_delayed = instr_i[`BMD_DELAY_BIT];
  // Only the indirect group carries an ELSE bit
  assign has_else = is_indgrp & instr_i[`BMD_ELSE_BIT];

  // Modify form: generator bit selects the upper or lower bank
  assign mod_isel = {instr_i[`BMD_GEN_BIT], instr_i[`BMD_ISEL_HI:`BMD_ISEL_LO]};
  assign mod_msel = {instr_i[`BMD_GEN_BIT], instr_i[`BMD_MSEL_HI:`BMD_MSEL_LO]};
  // Indirect branches address program memory, so the second generator
  assign br_isel = {1'b1, instr_i[`BMD_ISEL_HI:`BMD_ISEL_LO]};
  assign br_msel = {1'b1, instr_i[`BMD_MSEL_HI:`BMD_MSEL_LO]};

  assign mod_sum = index_ff[mod_isel] + modify_ff[mod_msel];
  assign br_sum = index_ff[br_isel] + modify_ff[br_msel];

  assign rel6 = instr_i[`BMD_REL6_HI:`BMD_REL6_LO];
  assign addr24 = instr_i[`BMD_ADDR_HI:`BMD_ADDR_LO];
  assign comp_field = instr_i[`BMD_COMP_HI:`BMD_COMP_LO];

  // Target by form; relative forms wrap within the 24-bit address space
  always @*
  begin
    target = pc_i;
    if (is_jabs)
    begin
      target = addr24;
    end
    else if (is_jrel)
    begin
      target = pc_i + addr24;
    end
    else if (is_ind)
    begin
      target = br_sum[23:0];
    end
    else if (is_irel)
    begin
      target = pc_i + {{18{rel6[5]}}, rel6};
    end
  end

  assign take = is_branch & predicate_select_ok;
  // A call ignores the loop-abort and clear-interrupt bits
  assign jump_take = take & ~is_call;
  assign do_abort = jump_take & instr_i[`BMD_ABORT_BIT];
  assign do_clrint = jump_take & instr_i[`BMD_CLRINT_BIT];
  assign mod_wr = is_modify & predicate_select_ok;

  // Compute runs beside the branch, or instead of it under ELSE
  assign comp_run = (comp_field != `BMD_COMP_NOP)
    & ((is_modify & predicate_select_ok)
    | (is_indgrp & ~has_else & predicate_select_ok)
    | (has_else & ~predicate_select_ok));

  // Sequential address and the address past the delay slots
  assign pc_next = pc_i + `BMD_STEP_NEXT;
  assign pc_after_delay = pc_i + `BMD_STEP_DELAYED;

  // Lowest set pointer bit is the routine now in service
  assign cur_irq = mask_ptr_ff & (~mask_ptr_ff + {{(NUM_IRQ-1){1'b0}}, 1'b1});
  assign clr_vec = do_clrint ? cur_irq : {NUM_IRQ{1'b0}};
  assign irq_one = {{(NUM_IRQ-1){1'b0}}, 1'b1};
  assign enter_vec = isr_enter_i ? (irq_one << isr_num_i) : {NUM_IRQ{1'b0}};

  // A request during its own routine is dropped; a request in the
  // clearing cycle is kept, so the set wins over the clear
  assign nxt_latch = (latch_ff & ~clr_vec & ~enter_vec)
    | (irq_req_i & ~(mask_ptr_ff & ~clr_vec));
  assign nxt_mask_ptr = (mask_ptr_ff & ~clr_vec) | enter_vec;


  // Register file; the software port writes and reads it by bank and number
  genvar k;
  generate
    for (k = 0; k < NUM_DAG; k = k + 1)
    begin : g_dag
      always @(posedge clock_i)
      begin
        if (!rst_n_i)
        begin
          index_ff[k] <= `BMD_RST_DAG;
          modify_ff[k] <= `BMD_RST_DAG;
        end
        else
        begin
          // Instruction write-back wins over a software write
          if (mod_wr && (mod_isel == k))
          begin
            index_ff[k] <= mod_sum;
          end
          else if (dag_wr_en_i && !dag_wr_sel_i[4] && (dag_wr_sel_i[3:0] == k))
          begin
            index_ff[k] <= dag_wr_data_i;
          end
          if (dag_wr_en_i && dag_wr_sel_i[4] && (dag_wr_sel_i[3:0] == k))
          begin
            modify_ff[k] <= dag_wr_data_i;
          end
        end
      end
    end
  endgenerate

  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      latch_ff <= `BMD_RST_IRQ;
      mask_ptr_ff <= `BMD_RST_IRQ;
      dag_rd_data_o <= `BMD_RST_DAG;
    end
    else
    begin
      latch_ff <= nxt_latch;
      mask_ptr_ff <= nxt_mask_ptr;
      // Read data stay until the next read strobe
      if (dag_rd_en_i)
      begin
        if (dag_rd_sel_i[4])
        begin
          dag_rd_data_o <= modify_ff[dag_rd_sel_i[3:0]];
        end
        else
        begin
          dag_rd_data_o <= index_ff[dag_rd_sel_i[3:0]];
        end
      end
    end
  end

  // Latch and pointer leave straight from their flops
  always @*
  begin
    interrupt_latch_reg_o = latch_ff;
    interrupt_mask_pointer_o = mask_ptr_ff;
  end

  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      branch_o <= 1'b0;
      call_o <= 1'b0;
      delayed_branch_o <= 1'b0;
      flush_o <= 1'b0;
      target_o <= `BMD_RST_PC;
      return_addr_o <= `BMD_RST_PC;
      next_pc_o <= `BMD_RST_PC;
      loop_pop_o <= 1'b0;
      pc_pop_o <= 1'b0;
      compute_en_o <= 1'b0;
      compute_o <= `BMD_COMP_NOP;
      modify_done_o <= 1'b0;
    end
    else
    begin
      // One-cycle pulses, answered in the cycle after the word
      branch_o <= take;
      call_o <= take & is_call;
      delayed_branch_o <= take & is_delayed;
      flush_o <= take & ~is_delayed;
      loop_pop_o <= do_abort;
      pc_pop_o <= do_abort;
      compute_en_o <= comp_run;
      // An empty field goes out as the no-operation code
      compute_o <= comp_run ? comp_field : `BMD_COMP_NOP;
      modify_done_o <= mod_wr;
      // Target and return address hold until the next taken branch
      if (take)
      begin
        target_o <= target;
        // A delayed call returns past the two slots it executes
        return_addr_o <= is_delayed ? pc_after_delay : pc_next;
        next_pc_o <= is_delayed ? pc_next : target;
      end
      else if (instr_valid_i)
      begin
        // Not taken, modify or unknown opcode: plain step
        next_pc_o <= pc_next;
      end
    end
  end

endmodule

`default_nettype wire

// file: bmd_regs.vh
// Field positions, opcodes and reset values for the branch and modify decoder
`ifndef BMD_REGS_VH
`define BMD_REGS_VH

// Upper opcode bits 47:40
`define BMD_OP_HI 47
`define BMD_OP_LO 40
`define BMD_OP_MODIFY 8'h04
`define BMD_OP_JUMP_ABS 8'h06
`define BMD_OP_JUMP_REL 8'h07
`define BMD_OP_IND 8'h08
`define BMD_OP_IND_REL 8'h09

// Shared single-bit fields
`define BMD_GEN_BIT 39
`define BMD_CALL_BIT 39
`define BMD_ABORT_BIT 38
`define BMD_DELAY_BIT 26
`define BMD_ELSE_BIT 25
`define BMD_CLRINT_BIT 24

// Predicate field and its always-true code
`define BMD_PREDICATE_SELECT_HI 37
`define BMD_PREDICATE_SELECT_LO 33
`define BMD_PREDICATE_SELECT_TRUE 5'h1F

// Index and modify selects, also used for the indirect branch
`define BMD_ISEL_HI 32
`define BMD_ISEL_LO 30
`define BMD_MSEL_HI 29
`define BMD_MSEL_LO 27

// Short PC-relative offset of the indirect group
`define BMD_REL6_HI 32
`define BMD_REL6_LO 27

// Long address field of the direct group
`define BMD_ADDR_HI 23
`define BMD_ADDR_LO 0

// Compute field and its no-operation code
`define BMD_COMP_HI 22
`define BMD_COMP_LO 0
`define BMD_COMP_NOP 23'h000000

// Sequential steps after the branch instruction
`define BMD_STEP_NEXT 24'h000001
`define BMD_STEP_DELAYED 24'h000003

// Reset values
`define BMD_RST_DAG 32'h00000000
`define BMD_RST_PC 24'h000000
`define BMD_RST_IRQ 32'h00000000

`endif

// file: bmd_decoder_props.sv
// Port checks for the branch and modify decoder
`timescale 1ns/1ps
`default_nettype none
module bmd_decoder_props #(
  parameter NUM_IRQ = 32,
  parameter NUM_PREDICATE_SELECT = 32
) (
  input wire clock_i, // Clock
  input wire rst_n_i, // Reset
  input wire instr_valid_i, // Valid
  input wire [47:0] instr_i, // Word
  input wire [23:0] pc_i, // Address
  input wire [NUM_PREDICATE_SELECT-1:0] predicate_select_flags_i, // Flags
  input wire isr_enter_i, // Entry
  input wire [NUM_IRQ-1:0] interrupt_latch_reg_o, // Latch
  input wire [NUM_IRQ-1:0] interrupt_mask_pointer_o, // Pointer
  input wire branch_o, // Taken
  input wire call_o, // Call
  input wire [23:0] target_o, // Target
  input wire [23:0] return_addr_o, // Return
  input wire [23:0] next_pc_o, // Next
  input wire loop_pop_o, // Loop pop
  input wire pc_pop_o, // PC pop
  input wire compute_en_o, // Compute
  input wire [22:0] compute_o, // Field
  input wire modify_done_o // Modify
);
  wire [7:0] op = instr_i[47:40];
  wire ok = (instr_i[37:33] == 5'h1F) | predicate_select_flags_i[instr_i[37:33]];
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_ABS_TARGET: assert property (instr_valid_i && op == 8'h06 && !instr_i[39] && ok
    |=> branch_o && target_o == $past(instr_i[23:0])) else $error("absolute target wrong");
  AST_CALL_PUSH: assert property (instr_valid_i && op == 8'h06 && instr_i[39] && !instr_i[26] && ok
    |=> call_o && return_addr_o == $past(pc_i) + 24'h000001) else $error("call return wrong");
  AST_CALL_NO_POP: assert property (call_o |-> !loop_pop_o && !pc_pop_o)
    else $error("call popped stacks");
  AST_ABORT_POP: assert property (instr_valid_i && op == 8'h06 && instr_i[39:38] == 2'h1 && ok
    |=> loop_pop_o && pc_pop_o) else $error("loop abort missing");
  AST_NOP_COMPUTE: assert property (instr_valid_i && instr_i[22:0] == 23'h000000
    |=> !compute_en_o && compute_o == 23'h000000) else $error("empty compute ran");
  AST_ELSE_TRUE: assert property (instr_valid_i && op == 8'h08 && instr_i[25] && ok
    |=> branch_o && !compute_en_o) else $error("else compute ran");
  AST_FALSE_SEQ: assert property (instr_valid_i && op == 8'h08 && !instr_i[25] && !ok
    |=> !branch_o && !loop_pop_o && next_pc_o == $past(pc_i) + 24'h000001) else $error("false branch moved");
  AST_NO_RELATCH: assert property (!instr_valid_i && !isr_enter_i
    |=> (interrupt_latch_reg_o & ~$past(interrupt_latch_reg_o) & $past(interrupt_mask_pointer_o)) == 0)
    else $error("interrupt in service latched");
  AST_MODIFY_DONE: assert property (instr_valid_i && op == 8'h04 |=> modify_done_o == $past(ok))
    else $error("modify gating wrong");
endmodule
`default_nettype wire

// file: bmd_decoder_tb.sv
// Testbench for the branch and modify decoder
`timescale 1ns/1ps
`default_nettype none
module bmd_decoder_tb;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic iv = 1'b0, we = 1'b0, re = 1'b0, isr = 1'b0;
  logic [47:0] w = 48'h0;
  logic [23:0] pc = 24'h0, tgt, ret, npc;
  logic [31:0] fl = 32'h0, irq = 32'h0, wd = 32'h0, rd, lat, mp;
  logic [4:0] ws = 5'h0, rs = 5'h0, num = 5'h2;
  logic br, cl, db, fs, lp, pp, ce, md;
  logic [22:0] cp;
  int n_fail = 0, n_checks = 0;
  bmd_decoder bmd_decoder_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(iv),
    .instr_i(w), .pc_i(pc), .predicate_select_flags_i(fl), .dag_wr_en_i(we), .dag_wr_sel_i(ws),
    .dag_wr_data_i(wd), .dag_rd_en_i(re), .dag_rd_sel_i(rs), .dag_rd_data_o(rd),
    .irq_req_i(irq), .isr_enter_i(isr), .isr_num_i(num), .interrupt_latch_reg_o(lat),
    .interrupt_mask_pointer_o(mp), .branch_o(br), .call_o(cl), .delayed_branch_o(db),
    .flush_o(fs), .target_o(tgt), .return_addr_o(ret), .next_pc_o(npc), .loop_pop_o(lp),
    .pc_pop_o(pp), .compute_en_o(ce), .compute_o(cp), .modify_done_o(md));
  initial
  begin
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic close_out;
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [47:0] mk(input logic [7:0] op, input logic [1:0] ba,
    input logic [4:0] cd, input logic [5:0] rg, input logic [2:0] jec, input logic [23:0] lo);
    mk = {op, ba, cd, rg, jec, lo};
  endfunction
  // One instruction, outputs looked at in the answer cycle
  task automatic run(input logic [47:0] x, input logic [23:0] p, input logic [31:0] f);
    @(posedge clock_i);
    iv <= 1'b1;
    w <= x;
    pc <= p;
    fl <= f;
    @(posedge clock_i);
    iv <= 1'b0;
    #1;
  endtask
  task automatic pulse(input logic [31:0] r, input logic e);
    @(posedge clock_i);
    irq <= r;
    isr <= e;
    @(posedge clock_i);
    irq <= 32'h0;
    isr <= 1'b0;
    #1;
  endtask
  task automatic dwr(input logic [4:0] s, input logic [31:0] d);
    @(posedge clock_i);
    we <= 1'b1;
    ws <= s;
    wd <= d;
    @(posedge clock_i);
    we <= 1'b0;
  endtask
  task automatic drd(input logic [4:0] s, input logic [31:0] e);
    @(posedge clock_i);
    re <= 1'b1;
    rs <= s;
    @(posedge clock_i);
    re <= 1'b0;
    #1;
    chk(rd, e);
  endtask
  initial
  begin
    repeat (5000) @(posedge clock_i);
    n_fail++;
    close_out();
  end
  initial
  begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    run(mk(8'h06, 2'h0, 5'h1F, 6'h00, 3'h0, 24'h000123), 24'h000010, 32'h0);
    chk({br, fs, db, tgt}, {3'h6, 24'h000123});
    chk(npc, 24'h000123);
    run(mk(8'h07, 2'h0, 5'h1F, 6'h00, 3'h4, 24'hFFFFF0), 24'h000100, 32'h0);
    chk({br, fs, db, tgt}, {3'h5, 24'h0000F0});
    chk(npc, 24'h000101);
    $display("direct branch test done");
    pulse(32'h0, 1'h1);
    pulse(32'h4, 1'h0);
    chk(lat, 32'h0);
    run(mk(8'h06, 2'h3, 5'h1F, 6'h00, 3'h1, 24'h000400), 24'h000020, 32'h0);
    chk({cl, lp, pp, ret}, {3'h4, 24'h000021});
    chk(mp, 32'h4);
    // A plain jump with loop abort and clear-interrupt then pops both stacks and ends the routine
    run(mk(8'h06, 2'h1, 5'h1F, 6'h00, 3'h1, 24'h000400), 24'h000030, 32'h0);
    chk({lp, pp, cl}, 3'h6);
    chk(mp, 32'h0);
    pulse(32'h4, 1'h0);
    chk(lat, 32'h4);
    $display("interrupt test done");
    dwr(5'h00, 32'h10);
    dwr(5'h10, 32'h5);
    run(mk(8'h04, 2'h0, 5'h1F, 6'h00, 3'h0, 24'h012345), 24'h000040, 32'h0);
    chk({md, ce, cp}, {2'h3, 23'h012345});
    drd(5'h00, 32'h15);
    run(mk(8'h04, 2'h0, 5'h03, 6'h00, 3'h0, 24'h012345), 24'h000041, 32'h0);
    chk({md, ce}, 2'h0);
    run(mk(8'h04, 2'h0, 5'h03, 6'h00, 3'h0, 24'h000000), 24'h000042, 32'h8);
    chk({md, ce, cp}, {2'h2, 23'h000000});
    drd(5'h00, 32'h1A);
    dwr(5'h09, 32'h100);
    dwr(5'h1A, 32'hFFFFFFFF);
    run(mk(8'h04, 2'h2, 5'h1F, 6'h0A, 3'h0, 24'h000000), 24'h000043, 32'h0);
    drd(5'h09, 32'hFF);
    $display("modify test done");
    dwr(5'h08, 32'h100);
    dwr(5'h18, 32'h20);
    run(mk(8'h08, 2'h0, 5'h1F, 6'h00, 3'h0, 24'h000007), 24'h000050, 32'h0);
    chk({br, ce, tgt}, {2'h3, 24'h000120});
    drd(5'h08, 32'h100);
    run(mk(8'h09, 2'h0, 5'h1F, 6'h3E, 3'h0, 24'h000000), 24'h000100, 32'h0);
    chk({br, tgt}, {1'h1, 24'h0000FE});
    run(mk(8'h08, 2'h0, 5'h03, 6'h00, 3'h2, 24'h000007), 24'h000060, 32'h0);
    chk({br, ce, npc}, {2'h1, 24'h000061});
    run(mk(8'h08, 2'h0, 5'h03, 6'h00, 3'h2, 24'h000007), 24'h000060, 32'h8);
    chk({br, ce}, 2'h2);
    run(mk(8'h08, 2'h0, 5'h03, 6'h00, 3'h0, 24'h000007), 24'h000070, 32'h0);
    chk({br, ce, lp, npc}, {3'h0, 24'h000071});
    $display("indirect branch test done");
    close_out();
  end
endmodule
bind bmd_decoder bmd_decoder_props #(.NUM_IRQ(NUM_IRQ), .NUM_PREDICATE_SELECT(NUM_PREDICATE_SELECT)) bmd_decoder_props_inst (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .pc_i(pc_i), .predicate_select_flags_i(predicate_select_flags_i), .isr_enter_i(isr_enter_i),
  .interrupt_latch_reg_o(interrupt_latch_reg_o), .interrupt_mask_pointer_o(interrupt_mask_pointer_o),
  .branch_o(branch_o), .call_o(call_o), .target_o(target_o), .return_addr_o(return_addr_o),
  .next_pc_o(next_pc_o), .loop_pop_o(loop_pop_o), .pc_pop_o(pc_pop_o),
  .compute_en_o(compute_en_o), .compute_o(compute_o), .modify_done_o(modify_done_o));
`default_nettype wire
